/* File: rtl/cycle_count_if.sv */
`timescale 1ns/1ps
// counts and costs handed to the summing unit, total handed back
interface cycle_count_if;
    import instr_timing_pkg::*;
    count_vec_t cnt;
    cost_vec_t cost;
    logic [TOTAL_W-1:0] total;
    modport calc (input cnt, input cost, output total);
    modport user (output cnt, output cost, input total);
endinterface

/* File: rtl/instr_timing_pkg.sv */
package instr_timing_pkg;

    // widths of the counting datapath
    localparam int KIND_NUM = 6;
    localparam int COUNT_W = 4;
    localparam int COST_W = 2;
    localparam int TOTAL_W = 9;
    localparam int ADDR_W = 24;
    localparam int COND_W = 4;

    // the six cycle kinds, in the order they are executed
    typedef enum logic [2:0] {
        KIND_FETCH = 3'h0,
        KIND_BRANCH_ADDR = 3'h1,
        KIND_STACK = 3'h2,
        KIND_BYTE = 3'h3,
        KIND_WORD = 3'h4,
        KIND_INTERNAL = 3'h5,
        KIND_NONE = 3'h6
    } cycle_kind_e;

    typedef logic [KIND_NUM-1:0][COUNT_W-1:0] count_vec_t;
    typedef logic [KIND_NUM-1:0][COST_W-1:0] cost_vec_t;

    // decoded instruction classes handled by the timing block
    typedef enum logic [4:0] {
        CLS_ADD_B_IMM = 5'h00,
        CLS_ADD_B_REG = 5'h01,
        CLS_ADD_W_IMM = 5'h02,
        CLS_ADD_W_REG = 5'h03,
        CLS_ADD_L_IMM = 5'h04,
        CLS_ADD_L_REG = 5'h05,
        CLS_ADD_SMALL = 5'h06,
        CLS_ADDC_IMM = 5'h07,
        CLS_ADDC_REG = 5'h08,
        CLS_AND_B_IMM = 5'h09,
        CLS_AND_B_REG = 5'h0A,
        CLS_AND_W_IMM = 5'h0B,
        CLS_AND_W_REG = 5'h0C,
        CLS_AND_L_IMM = 5'h0D,
        CLS_AND_L_REG = 5'h0E,
        CLS_AND_CCR = 5'h0F,
        CLS_BIT_AND = 5'h10,
        CLS_BRANCH8 = 5'h11,
        CLS_BRANCH16 = 5'h12
    } instr_class_e;

    // operand form of the bit-and-into-carry instruction
    typedef enum logic [1:0] {
        OPD_REG = 2'h0,
        OPD_INDIRECT = 2'h1,
        OPD_ABS8 = 2'h2
    } operand_mode_e;

    // branch names, primary forms then the aliases
    typedef enum logic [4:0] {
        BR_ALWAYS = 5'h00, BR_NEVER = 5'h01, BR_HIGHER = 5'h02, BR_LOWER_SAME = 5'h03,
        BR_CARRY_CLEAR = 5'h04, BR_CARRY_SET = 5'h05, BR_NOT_EQUAL = 5'h06,
        BR_EQUAL = 5'h07, BR_OVF_CLEAR = 5'h08, BR_OVF_SET = 5'h09, BR_PLUS = 5'h0A,
        BR_MINUS = 5'h0B, BR_GREATER_EQ = 5'h0C, BR_LESS = 5'h0D, BR_GREATER = 5'h0E,
        BR_LESS_EQ = 5'h0F, BR_TRUE = 5'h10, BR_FALSE = 5'h11,
        BR_HIGHER_SAME = 5'h12, BR_LOWER = 5'h13
    } branch_name_e;

    // states per cycle
    localparam logic [COST_W-1:0] MEM_STATES = 2'h2;
    localparam logic [COST_W-1:0] RAM_BYTE_STATES = 2'h2;
    localparam logic [COST_W-1:0] PERIPH_FAST_STATES = 2'h2;
    localparam logic [COST_W-1:0] PERIPH_SLOW_STATES = 2'h3;
    localparam logic [COST_W-1:0] INTERNAL_STATES = 2'h1;

    // cycle counts per instruction class
    localparam logic [COUNT_W-1:0] FETCH_ONE = 4'h1;
    localparam logic [COUNT_W-1:0] FETCH_IMM16 = 4'h2;
    localparam logic [COUNT_W-1:0] FETCH_IMM32 = 4'h3;
    localparam logic [COUNT_W-1:0] FETCH_LONG_AND = 4'h2;
    localparam logic [COUNT_W-1:0] FETCH_BIT_MEM = 4'h2;
    localparam logic [COUNT_W-1:0] BYTE_BIT_MEM = 4'h1;
    localparam logic [COUNT_W-1:0] FETCH_BRANCH = 4'h2;
    localparam logic [COUNT_W-1:0] INTERNAL_BRANCH16 = 4'h2;

    // peripheral address decode: page, module field, slow module map
    localparam int PAGE_HI = 23;
    localparam int PAGE_LO = 8;
    localparam int MOD_HI = 7;
    localparam int MOD_LO = 4;
    localparam logic [15:0] PERIPH_PAGE = 16'hFFFF;
    localparam logic [15:0] PERIPH_SLOW_MAP = 16'h00F0;

endpackage

/* File: rtl/instruction_state_count.sv */
// Functional notes
// - total is sum of count times cost
// - fetch, branch read, stack: two states
// - byte access to on-chip RAM: two states
// - peripheral access two or three, per module
// - internal operation cycle is one state
// - long immediate add/and: three fetches
// - word immediate add/and: two fetches
// - simple add_small_constant, byte and, condition and: one fetch
// - bit-and-carry memory: two fetches, one byte
// - short branch: two fetches, taken or not
// - branch aliases decode as primary forms
// - long branch: two fetches, two internal
`timescale 1ns/1ps
module instruction_state_count (
    input logic clk_in,
    input logic rst_n_in,
    input logic instr_valid_in,
    input instr_timing_pkg::instr_class_e instr_class_in,
    input instr_timing_pkg::operand_mode_e operand_mode_in,
    input instr_timing_pkg::branch_name_e branch_name_in,
    input logic [instr_timing_pkg::ADDR_W-1:0] data_addr_in,
    output logic instr_ready_out,
    output instr_timing_pkg::count_vec_t cycle_counts_out,
    output logic [instr_timing_pkg::TOTAL_W-1:0] total_states_out,
    output logic [instr_timing_pkg::COND_W-1:0] cond_code_out,
    output instr_timing_pkg::cycle_kind_e cycle_kind_out,
    output logic cycle_start_out,
    output logic busy_out,
    output logic done_out
);
    import instr_timing_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_DONE = 2'b10
    } seq_state_e;

    // first kind at or after a start index that has cycles left
    function automatic cycle_kind_e next_kind(input count_vec_t c, input logic [2:0] from);
        cycle_kind_e k;
        k = KIND_NONE;
        for (int i = KIND_NUM - 1; i >= 0; i--)
        begin
            if (i >= int'(from) && c[i] != '0)
            begin
                k = cycle_kind_e'(i[2:0]);
            end
        end
        return k;
    endfunction

    // alias names fold onto their primary condition codes
    function automatic logic [COND_W-1:0] branch_cond(input branch_name_e b);
        logic [COND_W-1:0] c;
        unique case (b)
            BR_TRUE: c = COND_W'(BR_ALWAYS);
            BR_FALSE: c = COND_W'(BR_NEVER);
            BR_HIGHER_SAME: c = COND_W'(BR_CARRY_CLEAR);
            BR_LOWER: c = COND_W'(BR_CARRY_SET);
            default: c = b[COND_W-1:0];
        endcase
        return c;
    endfunction

    seq_state_e state_q, state_d;
    cycle_kind_e kind_q, kind_d, nk;
    logic [COUNT_W-1:0] left_q, left_d;
    logic [COST_W-1:0] sub_q, sub_d;
    count_vec_t cnt_q, cnt_d, dec_cnt;
    cost_vec_t cost_q, cost_d, dec_cost;
    logic [TOTAL_W-1:0] total_q, total_d;
    logic [TOTAL_W-1:0] elapsed_q, elapsed_d;
    logic [COND_W-1:0] cond_q, cond_d;
    logic accept, periph, slow;
    logic [COST_W-1:0] data_cost;

    cycle_count_if cc ();

    // weighted sum of the freshly decoded instruction
    state_cost_sum u_sum (
        .cc(cc)
    );

    assign cc.cnt = dec_cnt;
    assign cc.cost = dec_cost;

    // new instruction only taken once the previous one has run out
    assign accept = (state_q == ST_IDLE) && instr_valid_in;

    // peripheral module decode picks two or three states per module
    assign periph = data_addr_in[PAGE_HI:PAGE_LO] == PERIPH_PAGE;
    assign slow = PERIPH_SLOW_MAP[data_addr_in[MOD_HI:MOD_LO]];
    assign data_cost = periph ? (slow ? PERIPH_SLOW_STATES : PERIPH_FAST_STATES)
                              : RAM_BYTE_STATES;

    // state cost of each cycle kind for this access location
    always_comb
    begin
        dec_cost = '0;
        dec_cost[KIND_FETCH] = MEM_STATES;
        dec_cost[KIND_BRANCH_ADDR] = MEM_STATES;
        dec_cost[KIND_STACK] = MEM_STATES;
        dec_cost[KIND_BYTE] = data_cost;
        dec_cost[KIND_WORD] = periph ? data_cost : MEM_STATES;
        dec_cost[KIND_INTERNAL] = INTERNAL_STATES;
    end

    // cycle counts of each instruction class
    always_comb
    begin
        dec_cnt = '0;
        unique case (instr_class_in)
            CLS_ADD_L_IMM, CLS_AND_L_IMM:
                dec_cnt[KIND_FETCH] = FETCH_IMM32;
            CLS_ADD_W_IMM, CLS_AND_W_IMM:
                dec_cnt[KIND_FETCH] = FETCH_IMM16;
            CLS_ADD_B_IMM, CLS_ADD_B_REG, CLS_ADD_W_REG, CLS_ADD_L_REG, CLS_ADD_SMALL,
            CLS_ADDC_IMM, CLS_ADDC_REG, CLS_AND_B_IMM, CLS_AND_B_REG, CLS_AND_W_REG,
            CLS_AND_CCR:
                dec_cnt[KIND_FETCH] = FETCH_ONE;
            CLS_AND_L_REG:
                dec_cnt[KIND_FETCH] = FETCH_LONG_AND;
            CLS_BIT_AND:
                if (operand_mode_in == OPD_REG)
                begin
                    dec_cnt[KIND_FETCH] = FETCH_ONE;
                end
                else
                begin
                    dec_cnt[KIND_FETCH] = FETCH_BIT_MEM;
                    dec_cnt[KIND_BYTE] = BYTE_BIT_MEM;
                end
            CLS_BRANCH8:
                dec_cnt[KIND_FETCH] = FETCH_BRANCH;
            CLS_BRANCH16:
            begin
                dec_cnt[KIND_FETCH] = FETCH_BRANCH;
                dec_cnt[KIND_INTERNAL] = INTERNAL_BRANCH16;
            end
            default:
                dec_cnt[KIND_FETCH] = FETCH_ONE;
        endcase
    end

    // sequencer: walks the kinds in order, one state per clock
    always_comb
    begin
        state_d = state_q;
        kind_d = kind_q;
        left_d = left_q;
        sub_d = sub_q;
        cnt_d = cnt_q;
        cost_d = cost_q;
        total_d = total_q;
        cond_d = cond_q;
        elapsed_d = elapsed_q;
        nk = KIND_NONE;
        unique case (state_q)
            ST_IDLE:
                if (accept)
                begin
                    nk = next_kind(dec_cnt, KIND_FETCH);
                    cnt_d = dec_cnt;
                    cost_d = dec_cost;
                    total_d = cc.total;
                    cond_d = branch_cond(branch_name_in);
                    kind_d = nk;
                    left_d = dec_cnt[nk];
                    sub_d = dec_cost[nk];
                    elapsed_d = '0;
                    state_d = ST_RUN;
                end
            ST_RUN:
            begin
                elapsed_d = elapsed_q + 1'b1;
                if (sub_q > 2'h1)
                begin
                    sub_d = sub_q - 1'b1;
                end
                else if (left_q > 4'h1)
                begin
                    left_d = left_q - 1'b1;
                    sub_d = cost_q[kind_q];
                end
                else
                begin
                    nk = next_kind(cnt_q, 3'(kind_q + 1'b1));
                    if (nk == KIND_NONE)
                    begin
                        state_d = ST_DONE;
                    end
                    else
                    begin
                        kind_d = nk;
                        left_d = cnt_q[nk];
                        sub_d = cost_q[nk];
                    end
                end
            end
            ST_DONE:
                state_d = ST_IDLE;
            default:
                state_d = ST_IDLE;
        endcase
    end

    // sequencer registers
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_q <= ST_IDLE;
            kind_q <= KIND_NONE;
            left_q <= '0;
            sub_q <= '0;
            cnt_q <= '0;
            cost_q <= '0;
            total_q <= '0;
            cond_q <= '0;
            elapsed_q <= '0;
        end
        else
        begin
            state_q <= state_d;
            kind_q <= kind_d;
            left_q <= left_d;
            sub_q <= sub_d;
            cnt_q <= cnt_d;
            cost_q <= cost_d;
            total_q <= total_d;
            cond_q <= cond_d;
            elapsed_q <= elapsed_d;
        end
    end

    // outputs
    assign instr_ready_out = state_q == ST_IDLE;
    assign busy_out = state_q == ST_RUN;
    assign done_out = state_q == ST_DONE;
    assign cycle_kind_out = busy_out ? kind_q : KIND_NONE;
    assign cycle_start_out = busy_out && (sub_q == cost_q[kind_q]) && (sub_q != '0);
    assign cycle_counts_out = cnt_q;
    assign total_states_out = total_q;
    assign cond_code_out = cond_q;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    // a take of one class, and a count set holding fetches only
    sequence take_s(instr_class_e c);
        instr_valid_in && instr_ready_out && instr_class_in == c;
    endsequence

    sequence fetch_only_s(logic [COUNT_W-1:0] n);
        cycle_counts_out[KIND_FETCH] == n && cycle_counts_out[KIND_BYTE] == '0 &&
            cycle_counts_out[KIND_INTERNAL] == '0 && cycle_counts_out[KIND_WORD] == '0;
    endsequence

    // a fetch state is followed by a second one, then a new cycle or the end
    sequence fetch_tail_s;
        (cycle_kind_out == KIND_FETCH && !cycle_start_out) ##1 (cycle_start_out || !busy_out);
    endsequence

    total_sum_a: assert property (done_out |-> elapsed_q == total_states_out)
        else $error("states run differ from computed total");
    fetch_cost_a: assert property (cycle_kind_out == KIND_FETCH && cycle_start_out
        |=> fetch_tail_s)
        else $error("fetch cycle not two states");
    ram_byte_a: assert property (accept && !periph |=> cost_q[KIND_BYTE] == 2'h2)
        else $error("on-chip ram byte access not two states");
    periph_cost_a: assert property (accept && periph
        |=> cost_q[KIND_BYTE] == ($past(slow) ? 2'h3 : 2'h2))
        else $error("peripheral access cost wrong for module");
    word_cost_a: assert property (accept && periph
        |=> cost_q[KIND_WORD] == cost_q[KIND_BYTE])
        else $error("peripheral word access cost differs from byte");
    internal_cost_a: assert property (cycle_kind_out == KIND_INTERNAL
        |-> cycle_start_out)
        else $error("internal cycle longer than one state");
    imm32_a: assert property (take_s(CLS_ADD_L_IMM) |=> fetch_only_s(4'h3))
        else $error("long immediate add not three fetches");
    imm16_a: assert property (take_s(CLS_AND_W_IMM) |=> fetch_only_s(4'h2))
        else $error("word immediate and not two fetches");
    one_fetch_a: assert property (take_s(CLS_AND_CCR)
        |=> fetch_only_s(4'h1) ##0 (total_states_out == 9'h2))
        else $error("condition code and not one fetch");
    long_and_a: assert property (take_s(CLS_AND_L_REG) |=> fetch_only_s(4'h2))
        else $error("long register and not two fetches");
    bit_mem_a: assert property (take_s(CLS_BIT_AND) && operand_mode_in != OPD_REG
        |=> cycle_counts_out[KIND_FETCH] == 4'h2 && cycle_counts_out[KIND_BYTE] == 4'h1)
        else $error("bit and memory counts wrong");
    branch8_a: assert property (take_s(CLS_BRANCH8) |=> busy_out [*4] ##1 done_out)
        else $error("short branch not four states");
    alias_a: assert property (instr_valid_in && instr_ready_out
        && branch_name_in == BR_LOWER |=> cond_code_out == 4'h5)
        else $error("lower alias not decoded as carry set");
    done_ready_a: assert property (done_out |=> instr_ready_out && !done_out)
        else $error("done not followed by ready");
    branch16_a: assert property (take_s(CLS_BRANCH16) |=> busy_out [*6] ##1 done_out)
        else $error("long branch not six states");
    no_early_a: assert property (busy_out |-> !instr_ready_out)
        else $error("next instruction accepted too early");

endmodule

/* File: rtl/state_cost_sum.sv */
`timescale 1ns/1ps
module state_cost_sum (
    cycle_count_if.calc cc
);
    import instr_timing_pkg::*;

    // one weighted term: cycles of a kind times states per cycle
    function automatic logic [TOTAL_W-1:0] term(input logic [COUNT_W-1:0] n,
                                                input logic [COST_W-1:0] s);
        logic [TOTAL_W-1:0] p;
        p = TOTAL_W'(n) * TOTAL_W'(s);
        return p;
    endfunction

    // sum of the six weighted terms
    always_comb
    begin
        logic [TOTAL_W-1:0] acc;
        acc = '0;
        for (int i = 0; i < KIND_NUM; i++)
        begin
            acc = acc + term(cc.cnt[i], cc.cost[i]);
        end
        cc.total = acc;
    end

endmodule

/* File: sim/instruction_state_count_bench.sv */
`timescale 1ns/1ps
`define CHECK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin err_count++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
module instruction_state_count_bench;
    import instr_timing_pkg::*;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic instr_valid_in = 1'b0;
    instr_class_e instr_class_in = CLS_ADD_B_IMM;
    operand_mode_e operand_mode_in = OPD_REG;
    branch_name_e branch_name_in = BR_ALWAYS;
    logic [ADDR_W-1:0] data_addr_in = '0;
    logic clear_in = 1'b0;
    logic instr_ready_out, cycle_start_out, busy_out, done_out, order_err;
    count_vec_t cycle_counts_out, starts;
    logic [TOTAL_W-1:0] total_states_out, states;
    logic [COND_W-1:0] cond_code_out;
    cycle_kind_e cycle_kind_out;
    int err_count = 0;
    int samples_checked = 0;

    instruction_state_count u_instruction_state_count (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .instr_valid_in(instr_valid_in), .instr_class_in(instr_class_in),
        .operand_mode_in(operand_mode_in), .branch_name_in(branch_name_in),
        .data_addr_in(data_addr_in), .instr_ready_out(instr_ready_out),
        .cycle_counts_out(cycle_counts_out), .total_states_out(total_states_out),
        .cond_code_out(cond_code_out), .cycle_kind_out(cycle_kind_out),
        .cycle_start_out(cycle_start_out), .busy_out(busy_out), .done_out(done_out));

    onchip_target_model u_onchip_target_model (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .clear_in(clear_in), .kind_in(cycle_kind_out), .start_in(cycle_start_out),
        .starts_out(starts), .states_out(states), .order_err_out(order_err));

    // 50 MHz clock
    always #10 clk_in = ~clk_in;

    task automatic tally_and_finish();
        if (err_count == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // states of one byte access at the given address
    function automatic logic [COST_W-1:0] byte_cost(input logic [ADDR_W-1:0] a);
        if (a[PAGE_HI:PAGE_LO] == PERIPH_PAGE)
            return PERIPH_SLOW_MAP[a[MOD_HI:MOD_LO]] ? PERIPH_SLOW_STATES : PERIPH_FAST_STATES;
        return RAM_BYTE_STATES;
    endfunction

    // offer one instruction, follow it to done and judge counts and timing
    task automatic run_instr(input instr_class_e cls, input operand_mode_e opd,
        input branch_name_e br, input logic [ADDR_W-1:0] addr,
        input logic [COUNT_W-1:0] nf, input logic [COUNT_W-1:0] nb,
        input logic [COUNT_W-1:0] ni, input bit poke);
        logic [TOTAL_W-1:0] exp_t;
        int k;
        exp_t = TOTAL_W'(nf) * TOTAL_W'(MEM_STATES) + TOTAL_W'(nb) * TOTAL_W'(byte_cost(addr))
            + TOTAL_W'(ni) * TOTAL_W'(INTERNAL_STATES);
        k = 0;
        @(negedge clk_in);
        while (instr_ready_out !== 1'b1 && k < 20)
        begin
            k++;
            @(negedge clk_in);
        end
        if (k == 20)
        begin
            err_count++;
            tally_and_finish();
        end
        instr_class_in = cls;
        operand_mode_in = opd;
        branch_name_in = br;
        data_addr_in = addr;
        instr_valid_in = 1'b1;
        clear_in = 1'b1;
        @(negedge clk_in);
        instr_valid_in = 1'b0;
        clear_in = 1'b0;
        k = 1;
        while (done_out !== 1'b1 && k < 40)
        begin
            `CHECK("busy", 1'b1, busy_out)
            `CHECK("ready_in_run", 1'b0, instr_ready_out)
            instr_valid_in = poke && (k == 2); // offered while busy, must be ignored
            instr_class_in = poke ? CLS_BRANCH16 : cls;
            @(negedge clk_in);
            k++;
        end
        instr_valid_in = 1'b0;
        if (k == 40)
        begin
            err_count++; // no done within the bound counts as a mismatch
            tally_and_finish();
        end
        `CHECK("done_cycle", exp_t + 1, TOTAL_W'(k))
        `CHECK("total", exp_t, total_states_out)
        `CHECK("fetch_cnt", nf, cycle_counts_out[KIND_FETCH])
        `CHECK("byte_cnt", nb, cycle_counts_out[KIND_BYTE])
        `CHECK("int_cnt", ni, cycle_counts_out[KIND_INTERNAL])
        `CHECK("model_states", exp_t, states)
        `CHECK("model_fetch", nf, starts[KIND_FETCH])
        `CHECK("model_byte", nb, starts[KIND_BYTE])
        `CHECK("model_int", ni, starts[KIND_INTERNAL])
        `CHECK("model_order", 1'b0, order_err)
    endtask

    task automatic check_reset_state();
        `CHECK("rst_ready", 1'b1, instr_ready_out)
        `CHECK("rst_busy", 1'b0, busy_out)
        `CHECK("rst_kind", KIND_NONE, cycle_kind_out)
        `CHECK("rst_total", {TOTAL_W{1'b0}}, total_states_out)
    endtask

    // every single-fetch class
    task automatic one_fetch_group();
        instr_class_e one[11] = '{CLS_ADD_B_IMM, CLS_ADD_B_REG, CLS_ADD_W_REG, CLS_ADD_L_REG,
            CLS_ADD_SMALL, CLS_ADDC_IMM, CLS_ADDC_REG, CLS_AND_B_IMM, CLS_AND_B_REG,
            CLS_AND_W_REG, CLS_AND_CCR};
        foreach (one[i])
            run_instr(one[i], OPD_REG, BR_ALWAYS, '0, 4'h1, 4'h0, 4'h0, 0);
    endtask

    // immediate and long forms
    task automatic multi_fetch_group();
        run_instr(CLS_ADD_W_IMM, OPD_REG, BR_ALWAYS, '0, 4'h2, 4'h0, 4'h0, 0);
        run_instr(CLS_AND_W_IMM, OPD_REG, BR_ALWAYS, '0, 4'h2, 4'h0, 4'h0, 0);
        run_instr(CLS_ADD_L_IMM, OPD_REG, BR_ALWAYS, '0, 4'h3, 4'h0, 4'h0, 0);
        run_instr(CLS_AND_L_IMM, OPD_REG, BR_ALWAYS, '0, 4'h3, 4'h0, 4'h0, 1);
        run_instr(CLS_AND_L_REG, OPD_REG, BR_ALWAYS, '0, 4'h2, 4'h0, 4'h0, 0);
    endtask

    // bit-and with register, ram, fast and slow peripheral operands
    task automatic bit_and_group();
        run_instr(CLS_BIT_AND, OPD_REG, BR_ALWAYS, 24'h00FF00, 4'h1, 4'h0, 4'h0, 0);
        run_instr(CLS_BIT_AND, OPD_INDIRECT, BR_ALWAYS, 24'h00FF00,
            4'h2, 4'h1, 4'h0, 0);
        run_instr(CLS_BIT_AND, OPD_ABS8, BR_ALWAYS, 24'hFFFF10, 4'h2, 4'h1, 4'h0, 0);
        run_instr(CLS_BIT_AND, OPD_ABS8, BR_ALWAYS, 24'hFFFF50, 4'h2, 4'h1, 4'h0, 0);
        `CHECK("slow_total", 9'h007, total_states_out)
    endtask

    // every short branch name, aliases folded to the primary code
    task automatic branch_group();
        logic [COND_W-1:0] exp_c;
        for (int n = 0; n < 20; n++)
        begin
            run_instr(CLS_BRANCH8, OPD_REG, branch_name_e'(n), '0,
                4'h2, 4'h0, 4'h0, 0);
            case (n)
                16: exp_c = 4'h0;
                17: exp_c = 4'h1;
                18: exp_c = 4'h4;
                19: exp_c = 4'h5;
                default: exp_c = COND_W'(n);
            endcase
            `CHECK("cond", exp_c, cond_code_out)
        end
        run_instr(CLS_BRANCH16, OPD_REG, BR_LOWER, '0, 4'h2, 4'h0, 4'h2, 0);
        `CHECK("cond16", 4'h5, cond_code_out)
    endtask

    // reset in mid-instruction returns the block to idle at once
    task automatic reset_mid_run();
        run_instr(CLS_ADD_B_REG, OPD_REG, BR_ALWAYS, '0, 4'h1, 4'h0, 4'h0, 0);
        @(negedge clk_in);
        instr_class_in = CLS_BRANCH16;
        instr_valid_in = 1'b1;
        @(negedge clk_in);
        instr_valid_in = 1'b0;
        @(negedge clk_in);
        rst_n_in = 1'b0;
        #1;
        check_reset_state();
        @(negedge clk_in);
        rst_n_in = 1'b1;
        run_instr(CLS_BRANCH16, OPD_REG, BR_NEVER, '0, 4'h2, 4'h0, 4'h2, 0);
    endtask

    // main sequence
    initial
    begin
        repeat (12) @(negedge clk_in);
        check_reset_state();
        rst_n_in = 1'b1;
        one_fetch_group();
        multi_fetch_group();
        bit_and_group();
        branch_group();
        reset_mid_run();
        tally_and_finish();
    end
endmodule

/* File: sim/onchip_target_model.sv */
`timescale 1ns/1ps
// far-side memory model: tallies the cycles the core runs against it
module onchip_target_model (
    input logic clk_in,
    input logic rst_n_in,
    input logic clear_in,
    input instr_timing_pkg::cycle_kind_e kind_in,
    input logic start_in,
    output instr_timing_pkg::count_vec_t starts_out,
    output logic [instr_timing_pkg::TOTAL_W-1:0] states_out,
    output logic order_err_out
);
    import instr_timing_pkg::*;
    count_vec_t starts_q, starts_d;
    logic [TOTAL_W-1:0] states_q, states_d;
    cycle_kind_e last_q, last_d;
    logic order_err_q, order_err_d;

    // count states and cycle starts per kind, flag kinds out of order
    always_comb
    begin
        starts_d = starts_q;
        states_d = states_q;
        last_d = last_q;
        order_err_d = order_err_q;
        if (clear_in)
        begin
            starts_d = '0;
            states_d = '0;
            last_d = KIND_FETCH;
            order_err_d = 1'b0;
        end
        else if (kind_in != KIND_NONE)
        begin
            states_d = states_q + 1'b1;
            last_d = kind_in;
            if (kind_in < last_q)
                order_err_d = 1'b1; // kinds must run fetch first, internal last
            if (start_in)
                starts_d[kind_in] = starts_q[kind_in] + 1'b1;
        end
    end

    // register the tallies
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            starts_q <= '0;
            states_q <= '0;
            last_q <= KIND_FETCH;
            order_err_q <= 1'b0;
        end
        else
        begin
            starts_q <= starts_d;
            states_q <= states_d;
            last_q <= last_d;
            order_err_q <= order_err_d;
        end
    end

    assign starts_out = starts_q;
    assign states_out = states_q;
    assign order_err_out = order_err_q;
endmodule
